// ### rtl/i2st_pkg.sv
// Shared constants, register map and state codes for the two-wire slave
package i2st_pkg;
    // Register byte addresses on the Avalon-MM slave
    localparam logic [4:0] OFS_DATA = 5'h00;
    localparam logic [4:0] OFS_OWN = 5'h04;
    localparam logic [4:0] OFS_CTRL0 = 5'h08;
    localparam logic [4:0] OFS_CTRL1 = 5'h0c;
    localparam logic [4:0] OFS_TOC = 5'h10;
    // Reset values
    localparam logic [7:0] DATA_POR = 8'h00;
    localparam logic [7:0] OWN_POR = 8'h00;
    localparam logic [7:0] CTRL0_POR = 8'h00;
    localparam logic [7:0] CTRL1_POR = 8'h81;
    localparam logic [7:0] TOC_POR = 8'h00;
    // Control 0 field: interface enable
    localparam int C0_EN = 1;
    // Control 1 fields
    localparam int C1_DONE = 7;
    localparam int C1_MATCH = 6;
    localparam int C1_BUSY = 5;
    localparam int C1_TXSEL = 4;
    localparam int C1_ACK_TO_SEND = 3;
    localparam int C1_SRW = 2;
    localparam int C1_ACK_RECEIVED_FLAG = 0;
    // Bits of control 1 that software may write
    localparam logic [7:0] C1_SW_MASK = 8'h1a;
    // Time-out control fields
    localparam int TOC_EN = 7;
    localparam int TOC_FLAG = 6;
    // Bits per data byte and sub-clock prescale
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [4:0] SUB_DIV_LAST = 5'h1f;
    // Slave protocol states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_ADDR_ACK = 3'b010,
        ST_HOLD = 3'b011,
        ST_TX = 3'b100,
        ST_ACK_RX = 3'b101,
        ST_RX = 3'b110,
        ST_ACK_TX = 3'b111
    } i2st_state_e;
    // Waiting for stop after a refused byte shares the idle code
    localparam i2st_state_e ST_WAIT_STOP = ST_IDLE;
endpackage

// ### rtl/i2st_sync.sv
// Two-flop synchroniser for a slow level entering the system clock
`timescale 1ns/1ps
module i2st_sync
    import i2st_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic nrst, // Synchronous reset, active low
    input wire logic d, // Asynchronous level
    output logic q // Synchronised level
);
    logic meta; // First stage, read only by the second
    logic next_meta; // Next first stage
    logic next_q; // Next second stage

    // Shift the level through two stages
    always_comb begin
        next_meta = d;
        next_q = meta;
    end

    // Register both stages
    always_ff @(posedge clk) begin
        if (!nrst) begin
            meta <= 1'b0;
            q <= 1'b0;
        end else begin
            meta <= next_meta;
            q <= next_q;
        end
    end
endmodule

// ### rtl/i2st_timeout.sv
// Bus time-out counter clocked by the sub-clock divided by 32
`timescale 1ns/1ps
module i2st_timeout
    import i2st_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic nrst, // Synchronous reset, active low
    input wire logic sub_lvl, // Synchronised sub-clock level
    input wire logic arm, // Start plus address match pulse
    input wire logic kick, // Serial clock falling edge
    input wire logic halt, // Stop condition seen
    input wire logic enable, // Time-out enable bit
    input wire logic [5:0] period, // Period select field
    output logic expired // One-cycle time-out pulse
);
    logic sub_q; // Previous sub-clock level
    logic [4:0] div; // Divide-by-32 prescaler
    logic running; // Counter armed
    logic [5:0] cnt; // Ticks since last falling edge
    logic next_sub_q, next_running, next_expired;
    logic [4:0] next_div;
    logic [5:0] next_cnt;
    logic tick;

    // Prescale, arm, clear and compare
    always_comb begin
        next_sub_q = sub_lvl;
        next_div = div;
        tick = 1'b0;
        next_running = running;
        next_cnt = cnt;
        next_expired = 1'b0;
        if (sub_lvl && !sub_q) begin
            next_div = div + 5'h01;
            tick = (div == SUB_DIV_LAST);
        end
        if (halt || !enable) begin
            next_running = 1'b0;
            next_cnt = 6'h00;
        end else if (arm) begin
            next_running = 1'b1;
            next_cnt = 6'h00;
            // Prescaler restarts so no partial tick shortens the period
            next_div = 5'h00;
        end else if (running) begin
            if (kick) begin
                next_cnt = 6'h00;
                next_div = 5'h00;
            end else if (tick) begin
                if (cnt == period) begin
                    next_expired = 1'b1;
                    next_running = 1'b0;
                    next_cnt = 6'h00;
                end else begin
                    next_cnt = cnt + 6'h01;
                end
            end
        end
    end

    // Register counter state
    always_ff @(posedge clk) begin
        if (!nrst) begin
            sub_q <= 1'b0;
            div <= 5'h00;
            running <= 1'b0;
            cnt <= 6'h00;
            expired <= 1'b0;
        end else begin
            sub_q <= next_sub_q;
            div <= next_div;
            running <= next_running;
            cnt <= next_cnt;
            expired <= next_expired;
        end
    end
endmodule

// ### rtl/i2st_top.sv
// Two-wire bus slave with shared data buffer, clock hold and time-out
//
// The Avalon-MM interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
// How it works
// - Read request only recorded; software makes slave transmitter
// - Own address match drives address acknowledge
// - Transmit select written by software, not set from read/write request
// - Eight-bit bytes, MSB first, after acknowledge
// - Programmed acknowledge driven on ninth clock
// - Master refusal releases data, await stop
// - Shared buffer holds every data byte
// - Hold clock low until buffer serviced
// - Counter armed by match, cleared on fall
// - Time-out when period passes without fall
// - Stop condition halts time-out counting
// - Overflow halts, disables, flags, interrupts
// - Time-out restores control 1 only
// - Flag set by hardware, cleared by software
// - Period is field plus one ticks of 32 sub-clock cycles
// - Eighth bit captured as read request
// - Byte done flag rises after eight bits
// - Busy set by start, cleared by stop
// - Received acknowledge flag zero when acknowledged
module i2st_top
    import i2st_pkg::*;
(
    input wire logic clk, // System clock, 100 MHz
    input wire logic nrst, // Synchronous reset, active low
    input wire logic [4:0] avs_address, // Register byte address
    input wire logic avs_read, // Read request
    input wire logic avs_write, // Write request
    input wire logic [31:0] avs_writedata, // Write data
    input wire logic [3:0] avs_byteenable, // Byte lanes
    output logic [31:0] avs_readdata, // Read data
    output logic avs_waitrequest, // Stall
    input wire logic scl_in, // Clock line level
    output logic scl_out, // Clock line drive value
    output logic scl_oe_n, // Clock line pull-down, active low
    input wire logic sda_in, // Data line level
    output logic sda_out, // Data line drive value
    output logic sda_oe_n, // Data line pull-down, active low
    input wire logic sub_clk, // Slow sub-clock
    output logic bus_irq // Interrupt pulse
);
    i2st_state_e st, next_st; // Protocol state
    logic [3:0] cnt, next_cnt; // Bit counter
    logic [7:0] shreg, next_shreg; // Shift register
    logic [7:0] serial_data_buffer, next_serial_data_buffer; // Shared data
    logic [7:0] own_address_reg, next_own_address_reg; // Own address in 7:1
    logic [7:0] bus_control_0, next_bus_control_0; // Enable
    logic [7:0] bus_control_1, next_bus_control_1; // Status and control
    logic [7:0] timeout_control_reg, next_timeout_control_reg; // Time-out
    logic scl_q, sda_q; // Previous line levels
    logic next_scl_oe_n, next_sda_oe_n, next_irq, next_wait;
    logic [7:0] next_rdata; // Read data byte
    logic [7:0] rdata; // Registered read byte
    logic sub_lvl; // Synchronised sub-clock
    logic to_hit; // Time-out pulse
    logic arm; // Time-out arm pulse
    logic req, acc, wr_ok; // Bus request, accept, accepted write
    logic start_c, stop_c, rise, fall; // Line events

    assign avs_readdata = {24'h000000, rdata};
    assign req = avs_read || avs_write;
    assign acc = req && !avs_waitrequest;
    assign wr_ok = acc && avs_write && avs_byteenable[0];
    assign rise = scl_in && !scl_q;
    assign fall = !scl_in && scl_q;
    assign start_c = scl_in && scl_q && sda_q && !sda_in;
    assign stop_c = scl_in && scl_q && !sda_q && sda_in;

    i2st_sync u_sync (
        .clk(clk),
        .nrst(nrst),
        .d(sub_clk),
        .q(sub_lvl)
    );

    // Time-out counter
    i2st_timeout u_timeout (
        .clk(clk),
        .nrst(nrst),
        .sub_lvl(sub_lvl),
        .arm(arm),
        .kick(fall),
        .halt(stop_c),
        .enable(timeout_control_reg[TOC_EN]),
        .period(timeout_control_reg[5:0]),
        .expired(to_hit)
    );

    // Bus access, then line events, then time-out; later wins
    always_comb begin
        next_st = st;
        next_cnt = cnt;
        next_shreg = shreg;
        next_serial_data_buffer = serial_data_buffer;
        next_own_address_reg = own_address_reg;
        next_bus_control_0 = bus_control_0;
        next_bus_control_1 = bus_control_1;
        next_timeout_control_reg = timeout_control_reg;
        next_scl_oe_n = scl_oe_n;
        next_sda_oe_n = sda_oe_n;
        next_irq = 1'b0;
        arm = 1'b0;
        // One wait cycle per access keeps read data registered
        next_wait = !(req && avs_waitrequest);
        next_rdata = rdata;
        if (req && avs_waitrequest) begin
            case (avs_address)
                OFS_DATA: next_rdata = serial_data_buffer;
                OFS_OWN: next_rdata = own_address_reg;
                OFS_CTRL0: next_rdata = bus_control_0;
                OFS_CTRL1: next_rdata = bus_control_1;
                OFS_TOC: next_rdata = timeout_control_reg;
                default: next_rdata = 8'h00;
            endcase
        end
        // Register writes; unmapped addresses are ignored
        if (wr_ok) begin
            case (avs_address)
                OFS_DATA: begin
                    next_serial_data_buffer = avs_writedata[7:0];
                    if (st == ST_HOLD && bus_control_1[C1_TXSEL]) begin
                        next_shreg = avs_writedata[7:0];
                        next_sda_oe_n = avs_writedata[7];
                        next_scl_oe_n = 1'b1;
                        next_cnt = 4'h0;
                        next_bus_control_1[C1_DONE] = 1'b0;
                        next_st = ST_TX;
                    end
                end
                OFS_OWN: next_own_address_reg = avs_writedata[7:0];
                OFS_CTRL0: next_bus_control_0 = avs_writedata[7:0];
                OFS_CTRL1: begin
                    // Status bits are read only
                    next_bus_control_1 = (bus_control_1 & ~C1_SW_MASK) |
                        (avs_writedata[7:0] & C1_SW_MASK);
                end
                OFS_TOC: begin
                    next_timeout_control_reg[TOC_EN] = avs_writedata[TOC_EN];
                    next_timeout_control_reg[5:0] = avs_writedata[5:0];
                    next_timeout_control_reg[TOC_FLAG] =
                        timeout_control_reg[TOC_FLAG] & avs_writedata[TOC_FLAG];
                end
                default: begin
                end
            endcase
        end
        if (acc && avs_read && avs_address == OFS_DATA && st == ST_HOLD
                && !bus_control_1[C1_TXSEL]) begin
            next_scl_oe_n = 1'b1;
            next_cnt = 4'h0;
            next_bus_control_1[C1_DONE] = 1'b0;
            next_st = ST_RX;
        end
        // Serial protocol
        case (st)
            ST_ADDR: begin
                if (rise) begin
                    next_shreg = {shreg[6:0], sda_in};
                    next_cnt = cnt + 4'h1;
                end
                if (fall && cnt == BYTE_BITS) begin
                    if (shreg[7:1] == own_address_reg[7:1]) begin
                        next_bus_control_1[C1_MATCH] = 1'b1;
                        next_bus_control_1[C1_SRW] = shreg[0];
                        next_sda_oe_n = 1'b0;
                        next_irq = 1'b1;
                        arm = 1'b1;
                        next_st = ST_ADDR_ACK;
                    end else begin
                        next_st = ST_IDLE;
                    end
                end
            end
            ST_ADDR_ACK: begin
                if (fall) begin
                    next_sda_oe_n = 1'b1;
                    next_scl_oe_n = 1'b0;
                    next_st = ST_HOLD;
                end
            end
            ST_TX: begin
                if (rise) begin
                    next_cnt = cnt + 4'h1;
                end
                if (fall) begin
                    if (cnt == BYTE_BITS) begin
                        next_sda_oe_n = 1'b1;
                        next_bus_control_1[C1_DONE] = 1'b1;
                        next_irq = 1'b1;
                        next_st = ST_ACK_RX;
                    end else begin
                        next_shreg = {shreg[6:0], 1'b0};
                        next_sda_oe_n = shreg[6];
                    end
                end
            end
            ST_ACK_RX: begin
                if (rise) begin
                    next_bus_control_1[C1_ACK_RECEIVED_FLAG] = sda_in;
                end
                if (fall) begin
                    if (bus_control_1[C1_ACK_RECEIVED_FLAG]) begin
                        next_st = ST_WAIT_STOP;
                    end else begin
                        next_scl_oe_n = 1'b0;
                        next_st = ST_HOLD;
                    end
                end
            end
            ST_RX: begin
                if (rise) begin
                    next_shreg = {shreg[6:0], sda_in};
                    next_cnt = cnt + 4'h1;
                end
                if (fall && cnt == BYTE_BITS) begin
                    next_serial_data_buffer = shreg;
                    next_bus_control_1[C1_DONE] = 1'b1;
                    next_irq = 1'b1;
                    next_sda_oe_n = bus_control_1[C1_ACK_TO_SEND];
                    next_st = ST_ACK_TX;
                end
            end
            ST_ACK_TX: begin
                if (fall) begin
                    next_sda_oe_n = 1'b1;
                    next_scl_oe_n = 1'b0;
                    next_st = ST_HOLD;
                end
            end
            default: begin
            end
        endcase
        if (start_c) begin
            next_bus_control_1[C1_BUSY] = 1'b1;
            next_bus_control_1[C1_MATCH] = 1'b0;
            next_cnt = 4'h0;
            next_sda_oe_n = 1'b1;
            next_scl_oe_n = 1'b1;
            next_st = ST_ADDR;
        end
        if (stop_c) begin
            next_bus_control_1[C1_BUSY] = 1'b0;
            next_sda_oe_n = 1'b1;
            next_scl_oe_n = 1'b1;
            next_st = ST_IDLE;
        end
        // A disabled interface never touches the lines
        if (!bus_control_0[C0_EN]) begin
            next_sda_oe_n = 1'b1;
            next_scl_oe_n = 1'b1;
            next_st = ST_IDLE;
        end
        if (to_hit) begin
            next_timeout_control_reg[TOC_EN] = 1'b0;
            next_timeout_control_reg[TOC_FLAG] = 1'b1;
            next_bus_control_1 = CTRL1_POR;
            next_sda_oe_n = 1'b1;
            next_scl_oe_n = 1'b1;
            next_irq = 1'b1;
            next_st = ST_IDLE;
        end
    end

    // Register all state
    always_ff @(posedge clk) begin
        if (!nrst) begin
            st <= ST_IDLE;
            cnt <= 4'h0;
            shreg <= DATA_POR;
            serial_data_buffer <= DATA_POR;
            own_address_reg <= OWN_POR;
            bus_control_0 <= CTRL0_POR;
            bus_control_1 <= CTRL1_POR;
            timeout_control_reg <= TOC_POR;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            scl_oe_n <= 1'b1;
            sda_oe_n <= 1'b1;
            scl_out <= 1'b0;
            sda_out <= 1'b0;
            bus_irq <= 1'b0;
            avs_waitrequest <= 1'b1;
            rdata <= 8'h00;
        end else begin
            st <= next_st;
            cnt <= next_cnt;
            shreg <= next_shreg;
            serial_data_buffer <= next_serial_data_buffer;
            own_address_reg <= next_own_address_reg;
            bus_control_0 <= next_bus_control_0;
            bus_control_1 <= next_bus_control_1;
            timeout_control_reg <= next_timeout_control_reg;
            scl_q <= scl_in;
            sda_q <= sda_in;
            scl_oe_n <= next_scl_oe_n;
            sda_oe_n <= next_sda_oe_n;
            scl_out <= 1'b0;
            sda_out <= 1'b0;
            bus_irq <= next_irq;
            avs_waitrequest <= next_wait;
            rdata <= next_rdata;
        end
    end

    a_addr_ack_low: assert property (@(posedge clk) disable iff (!nrst)
        st == ST_ADDR_ACK |-> !sda_oe_n) else $error("address ack not driven");
    a_hold_scl_low: assert property (@(posedge clk) disable iff (!nrst)
        st == ST_HOLD |-> !scl_oe_n) else $error("clock not held");
    a_rx_ack_value: assert property (@(posedge clk) disable iff (!nrst)
        (st == ST_RX && fall && cnt == BYTE_BITS && !start_c && !stop_c && !to_hit
            && bus_control_0[C0_EN])
        |=> st == ST_ACK_TX && sda_oe_n == $past(bus_control_1[C1_ACK_TO_SEND]))
        else $error("wrong receive ack");
    a_done_byte_irq: assert property (@(posedge clk) disable iff (!nrst)
        (st == ST_RX && fall && cnt == BYTE_BITS && !to_hit)
        |=> bus_control_1[C1_DONE] && bus_irq) else $error("byte done missing");
    a_busy_on_start: assert property (@(posedge clk) disable iff (!nrst)
        (start_c && !to_hit) |=> bus_control_1[C1_BUSY]) else $error("busy not set");
    a_timeout_effect: assert property (@(posedge clk) disable iff (!nrst)
        to_hit |=> !timeout_control_reg[TOC_EN] && timeout_control_reg[TOC_FLAG]
            && bus_control_1 == CTRL1_POR && bus_irq && scl_oe_n)
        else $error("time-out effect missing");
    a_flag_sticky: assert property (@(posedge clk) disable iff (!nrst)
        (timeout_control_reg[TOC_FLAG] && !(wr_ok && avs_address == OFS_TOC))
        |=> timeout_control_reg[TOC_FLAG]) else $error("flag lost");
    a_srw_capture: assert property (@(posedge clk) disable iff (!nrst)
        (st == ST_ADDR && fall && cnt == BYTE_BITS && !to_hit
            && shreg[7:1] == own_address_reg[7:1] && bus_control_0[C0_EN])
        |=> bus_control_1[C1_SRW] == $past(shreg[0])) else $error("srw not captured");
endmodule

// ### testbench/i2st_master.sv
// Behavioural two-wire bus master that faces the slave
`timescale 1ns/1ps
module i2st_master (
    input wire logic clk, // System clock
    input wire logic scl, // Clock line level
    input wire logic sda, // Data line level
    output logic scl_drv, // Clock drive, 0 pulls low
    output logic sda_drv // Data drive, 0 pulls low
);
    initial begin
        scl_drv = 1'b1;
        sda_drv = 1'b1;
    end
    // Quarter bit, slow enough for the slave's edge sampling
    task automatic q();
        repeat (4) @(posedge clk);
    endtask
    // Release clock; the slave may stretch it, the bench timeout ends a hang
    task automatic rise();
        scl_drv <= 1'b1;
        while (scl !== 1'b1) begin
            @(negedge clk);
        end
    endtask
    // One bit; a driven 1 releases the line so the slave can answer
    task automatic bit_io(input logic b, output logic r);
        sda_drv <= b;
        q();
        rise();
        q();
        @(negedge clk);
        r = sda;
        q();
        scl_drv <= 1'b0;
        q();
    endtask
    task automatic xfer(input logic [7:0] tx, input logic ai, output logic [7:0] rx,
                        output logic ao);
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
        bit_io(ai, ao);
    endtask
    // Start: data falls while clock is high
    task automatic start();
        sda_drv <= 1'b1;
        rise();
        q();
        sda_drv <= 1'b0;
        q();
        scl_drv <= 1'b0;
        q();
    endtask
    task automatic stop();
        sda_drv <= 1'b0;
        q();
        rise();
        q();
        sda_drv <= 1'b1;
        q();
    endtask
endmodule

// ### testbench/test_i2st_top.sv
// Self-checking bench for the two-wire slave with time-out
`timescale 1ns/1ps
module test_i2st_top;
    import i2st_pkg::*;
    logic clk, nrst, sub_clk, avs_read, avs_write, scl_out, scl_oe_n, sda_out, sda_oe_n;
    logic bus_irq, avs_waitrequest, m_scl, m_sda, ak;
    logic [4:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, r;
    logic [3:0] avs_byteenable;
    logic [7:0] rx;
    int fail_count, total_checks, irqs, cyc;
    // Open-drain lines with pull-ups
    wire scl_ln = m_scl & (scl_oe_n | scl_out);
    wire sda_ln = m_sda & (sda_oe_n | sda_out);
    i2st_top DUT (.clk(clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .scl_in(scl_ln),
        .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda_ln), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .sub_clk(sub_clk), .bus_irq(bus_irq));
    i2st_master m (.clk(clk), .scl(scl_ln), .sda(sda_ln), .scl_drv(m_scl), .sda_drv(m_sda));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Sub-clock period unrelated to the system clock
    initial begin
        sub_clk = 1'b0;
        forever #41 sub_clk = ~sub_clk;
    end
    // Interrupt pulses and hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (bus_irq === 1'b1) irqs <= irqs + 1;
        if (cyc == 30000) begin
            fail_count++;
            print_verdict();
        end
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, s, e);
        end
    endtask
    // Avalon access held until waitrequest is sampled low at a rising edge
    task automatic acc(input logic w, input logic [4:0] a, input logic [7:0] d,
                       input logic [3:0] be);
        @(posedge clk);
        avs_write <= w;
        avs_read <= !w;
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_byteenable <= be;
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        r = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        acc(1'b1, a, d, 4'h1);
    endtask
    task automatic rchk(input logic [4:0] a, input logic [31:0] mk, input logic [31:0] e);
        acc(1'b0, a, 8'h00, 4'h1);
        chk(r & mk, e);
    endtask
    task automatic t_reset();
        rchk(OFS_CTRL1, 32'hffffffff, 32'h81);
        rchk(OFS_TOC, 32'hffffffff, 32'h00);
        acc(1'b1, OFS_OWN, 8'h77, 4'h0);
        rchk(OFS_OWN, 32'hffffffff, 32'h00);
        wr(5'h14, 8'h55);
        rchk(5'h14, 32'hffffffff, 32'h00);
        $display("test reset done");
    endtask
    task automatic t_write();
        int n;
        wr(OFS_OWN, 8'hb4);
        wr(OFS_CTRL0, 8'h02);
        n = irqs;
        m.start();
        m.xfer(8'hb4, 1'b1, rx, ak);
        chk(ak, 1'b0);
        rchk(OFS_CTRL1, 32'h64, 32'h60);
        chk(scl_oe_n, 1'b0);
        wr(OFS_CTRL1, 8'h00);
        rchk(OFS_DATA, 32'hffffffff, 32'h00);
        repeat (2) @(negedge clk);
        chk(scl_oe_n, 1'b1);
        m.xfer(8'ha5, 1'b1, rx, ak);
        chk(ak, 1'b0);
        rchk(OFS_CTRL1, 32'h80, 32'h80);
        chk(irqs, n + 2);
        rchk(OFS_DATA, 32'hffffffff, 32'ha5);
        wr(OFS_CTRL1, 8'h08);
        m.xfer(8'h3c, 1'b1, rx, ak);
        chk(ak, 1'b1);
        rchk(OFS_DATA, 32'hffffffff, 32'h3c);
        m.stop();
        rchk(OFS_CTRL1, 32'h20, 32'h00);
        $display("test write done");
    endtask
    task automatic t_read();
        m.start();
        m.xfer(8'hb5, 1'b1, rx, ak);
        chk(ak, 1'b0);
        rchk(OFS_CTRL1, 32'h64, 32'h64);
        wr(OFS_CTRL1, 8'h10);
        rchk(OFS_CTRL1, 32'h10, 32'h10);
        wr(OFS_DATA, 8'h3c);
        m.xfer(8'hff, 1'b0, rx, ak);
        chk(rx, 8'h3c);
        rchk(OFS_CTRL1, 32'h01, 32'h00);
        wr(OFS_DATA, 8'hc3);
        m.xfer(8'hff, 1'b1, rx, ak);
        chk(rx, 8'hc3);
        rchk(OFS_CTRL1, 32'h01, 32'h01);
        chk(sda_oe_n, 1'b1);
        m.stop();
        m.start();
        m.xfer(8'h22, 1'b1, rx, ak);
        chk(ak, 1'b1);
        m.stop();
        $display("test read done");
    endtask
    task automatic t_timeout();
        int n;
        wr(OFS_TOC, 8'h81);
        m.start();
        m.xfer(8'hb4, 1'b1, rx, ak);
        n = irqs;
        // Past one tick but short of two: a period one tick short would fire here
        repeat (400) @(posedge clk);
        rchk(OFS_TOC, 32'hff, 32'h81);
        for (int i = 0; i < 1000 && irqs == n; i++) @(posedge clk);
        chk(irqs, n + 1);
        rchk(OFS_TOC, 32'hff, 32'h41);
        rchk(OFS_CTRL1, 32'hff, 32'h81);
        rchk(OFS_OWN, 32'hff, 32'hb4);
        rchk(OFS_CTRL0, 32'hff, 32'h02);
        chk(scl_oe_n, 1'b1);
        wr(OFS_TOC, 8'h41);
        rchk(OFS_TOC, 32'hff, 32'h41);
        wr(OFS_TOC, 8'h01);
        rchk(OFS_TOC, 32'hff, 32'h01);
        m.stop();
        $display("test timeout done");
    endtask
    // Stop after a match must halt the counter before it expires
    task automatic t_halt();
        wr(OFS_TOC, 8'h81);
        m.start();
        m.xfer(8'hb4, 1'b1, rx, ak);
        rchk(OFS_DATA, 32'hffffffff, 32'hc3);
        m.stop();
        repeat (700) @(posedge clk);
        rchk(OFS_TOC, 32'hff, 32'h81);
        $display("test halt done");
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        {avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = '0;
        {fail_count, total_checks, irqs, cyc} = '0;
        nrst = 1'b0;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        t_reset();
        t_write();
        t_read();
        t_timeout();
        t_halt();
        print_verdict();
    end
endmodule
